// ===== rdbk_monitor.sv
// Port checks for the two-wire readback target
`timescale 1ns/1ps
`default_nettype none
module rdbk_monitor (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        scl_in,
    input wire logic        scl_out,
    input wire logic        scl_oe,
    input wire logic        sda_out,
    input wire logic        sda_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // One wait state per request; a clock high phase
    sequence one_wait;
        waitrequest ##1 !waitrequest;
    endsequence
    sequence scl_high;
        scl_in [*6];
    endsequence
    // Register bus handshake
    wait_once_a: assert property ($rose(read || write) |-> one_wait)
        else $error("request not answered after one wait");
    idle_ready_a: assert property (!(read || write) |-> !waitrequest)
        else $error("wait raised without request");
    rdata_hold_a: assert property (!read |=> $stable(readdata))
        else $error("read data moved without read");
    // Open-drain pins
    open_drain_a: assert property (!sda_out && !scl_out)
        else $error("pin value not low");
    reset_quiet_a: assert property ($rose(nrst) |-> !sda_oe && !scl_oe)
        else $error("pin pulled after reset");
    sda_hold_a: assert property (scl_high |-> $stable(sda_oe))
        else $error("data moved while clock high");
    drive_low_a: assert property ($rose(sda_oe) |->
        !scl_in && !$past(scl_in, 2)) else $error("data pulled too early");
    release_low_a: assert property ($fell(sda_oe) |-> !scl_in)
        else $error("data released while clock high");
endmodule : rdbk_monitor
bind rdbk_target rdbk_monitor mon (.mclk(mclk), .nrst(nrst), .read(read),
    .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// ===== rdbk_pkg.sv
// Constants and types shared by the two-wire readback target
package rdbk_pkg;
    // Fixed upper part of the seven-bit target address
    localparam logic [4:0]  ADDR_FIXED      = 5'h13;
    // Register word indices on the Avalon-MM slave
    localparam logic [3:0]  OFF_CODE0       = 4'h0;
    localparam logic [3:0]  OFF_CTRL        = 4'h4;
    localparam logic [3:0]  OFF_STATUS      = 4'h5;
    localparam logic [3:0]  OFF_LOG         = 4'h6;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
    localparam int          CTRL_EN_BIT     = 0;
    // Channel register fields
    localparam int          CODE_LSB        = 0;
    localparam int          CODE_W          = 12;
    localparam int          PM_LSB          = 12;
    localparam int          PM_W            = 2;
    // Status and log register fields
    localparam int          ST_BUSY_BIT     = 8;
    localparam int          ST_LOG_BIT      = 9;
    localparam int          LOG_VALID_BIT   = 8;
    // Control byte fields
    localparam int          CB_PD_BIT       = 0;
    localparam int          CB_SEL_LSB      = 1;
    localparam int          CB_MODE_LSB     = 4;
    localparam int          CB_EXT_LSB      = 6;
    localparam logic [7:0]  CB_RESET        = 8'h00;
    // Readback byte contents
    localparam logic [5:0]  PD_FILL         = 6'h3F;
    localparam logic [3:0]  LOW_FILL        = 4'h0;
    localparam logic [1:0]  LAST_PLAIN      = 2'h1;
    localparam logic [1:0]  LAST_PD         = 2'h2;
    // Control byte log
    localparam int          LOG_WIDTH       = 8;
    localparam int          LOG_DEPTH       = 16;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CTRL, ST_CTRL_ACK,
        ST_TX, ST_TX_ACK, ST_IGNORE
    } tgt_state_t;
endpackage : rdbk_pkg

// ===== rdbk_target.sv
// Two-wire readback target of a quad 12-bit converter with Avalon-MM regs
//
// What this block does
// [RQ1] Start plus write address; low bits from pins
// [RQ2] Acknowledge own write address, data line low
// [RQ3] Control byte acknowledged; fields ext, mode, sel, pd
// [RQ4] Master repeats start, resends address for read
// [RQ5] Acknowledge read address, then drive data line
// [RQ6] Power flag selects two or three bytes
// [RQ7] Channel select picks code and power state
// [RQ8] Flag clear: high byte then low byte
// [RQ9] Flag set: power status, high, low
// [RQ10] High byte holds code 11..4, MSB first
// [RQ11] Low byte: code 3..0 in upper nibble
// [RQ12] Status byte: mode bits 7..6, rest ones
// [RQ13] Master not-acknowledges last byte, then stop
// [RQ14] Master prefers repeated start before next write
// [RQ15] Mode bits: 00/11 open, 01 1k, 10 100k
// [RQ16] After not-acknowledge release line, wait start
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

// Parameterised first-in first-out store with valid/ready on both sides
module rdbk_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                              (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire              empty = (wr_ptr == rd_ptr);
    wire              push  = in_valid && !full;
    wire              pop   = out_ready && !empty;
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr[AW-1:0]];
    // Storage write
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
    // Pointer update
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop)  rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule : rdbk_fifo

// Target logic and register slave
module rdbk_target
    import rdbk_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic        pin_addr_bit_hi,
    input  wire logic        pin_addr_bit_lo
);
    // Pin synchronisers; stage one feeds stage two only
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic       scl_d;
    logic       sda_d;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sync1 <= 4'hF;
            sync2 <= 4'hF;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            sync1 <= {scl_in, sda_in, pin_addr_bit_hi, pin_addr_bit_lo};
            sync2 <= sync1;
            scl_d <= sync2[3];
            sda_d <= sync2[2];
        end
    end

    // Bus condition decode
    wire scl_s    = sync2[3];
    wire sda_s    = sync2[2];
    wire scl_rise = scl_s && !scl_d;
    wire scl_fall = !scl_s && scl_d;
    wire start_c  = scl_s && scl_d && sda_d && !sda_s;
    wire stop_c   = scl_s && scl_d && !sda_d && sda_s;
    // Software registers
    logic [31:0] chan [4];
    logic [31:0] ctrl;
    logic        served;
    wire         req      = read || write;
    wire         done     = req && served;
    wire         en       = ctrl[CTRL_EN_BIT];
    wire         hit_code = (address < OFF_CTRL);
    wire         hit_ctrl = (address == OFF_CTRL);
    wire         hit_stat = (address == OFF_STATUS);
    wire         hit_log  = (address == OFF_LOG);
    wire [31:0]  be_mask  = {{8{byteenable[3]}}, {8{byteenable[2]}},
                             {8{byteenable[1]}}, {8{byteenable[0]}}};
    // Target state
    tgt_state_t  state;
    logic [7:0]  shift;
    logic [2:0]  bit_cnt;
    logic        got8;
    logic        rw_bit;
    logic [7:0]  cbyte;
    logic [1:0]  byte_idx;
    logic        drive_low;
    logic        stretch;
    // Control byte log
    logic        log_ready;
    logic        log_valid;
    logic [7:0]  log_data;
    wire         log_push = (state == ST_CTRL) && got8 && !scl_s;
    wire         log_pop  = done && read && hit_log;
    rdbk_fifo #(
        .WIDTH (LOG_WIDTH),
        .DEPTH (LOG_DEPTH)
    ) u_log (
        .mclk      (mclk),
        .nrst      (nrst),
        .in_valid  (log_push),
        .in_ready  (log_ready),
        .in_data   (shift),
        .out_valid (log_valid),
        .out_ready (log_pop),
        .out_data  (log_data)
    );
    // Address match against fixed bits and strapped pins
    wire [6:0]  own_addr  = {ADDR_FIXED, sync2[1], sync2[0]}; // RQ1
    wire        addr_hit  = (shift[7:1] == own_addr);
    // Selected channel and byte assembly
    wire [1:0]  sel       = cbyte[CB_SEL_LSB +: 2]; // RQ7
    wire        pd_flag   = cbyte[CB_PD_BIT];
    wire [31:0] sel_reg   = chan[sel]; // RQ7
    wire [11:0] sel_code  = sel_reg[CODE_LSB +: CODE_W];
    wire [1:0]  sel_pm    = sel_reg[PM_LSB +: PM_W]; // RQ15
    wire [7:0]  hi_byte   = sel_code[11:4]; // RQ10
    wire [7:0]  lo_byte   = {sel_code[3:0], LOW_FILL}; // RQ11
    wire [7:0]  pd_byte   = {sel_pm, PD_FILL}; // RQ12
    wire [1:0]  last_idx  = pd_flag ? LAST_PD : LAST_PLAIN; // RQ6
    wire [7:0]  first_tx  = pd_flag ? pd_byte : hi_byte; // RQ8 RQ9
    wire [1:0]  next_idx  = byte_idx + 2'h1;
    wire [7:0]  next_tx   = (pd_flag && next_idx == 2'h1) ? hi_byte
                                                          : lo_byte;
    wire        more      = (byte_idx != last_idx); // RQ6

    // Bit counter and byte-complete flag
    always_ff @(posedge mclk) begin
        if (!nrst || start_c) begin
            bit_cnt <= 3'h0;
            got8    <= 1'b0;
        end else if (scl_rise && (state == ST_ADDR || state == ST_CTRL
                                  || state == ST_TX)) begin
            bit_cnt <= bit_cnt + 3'h1;
            got8    <= (bit_cnt == 3'h7);
        end else if (scl_fall && (state == ST_ADDR_ACK
                                  || state == ST_TX_ACK)) begin
            got8    <= 1'b0;
        end else if (log_push && log_ready) begin
            got8    <= 1'b0;
        end
    end

    // Byte shifter: receive on rising clock, transmit on falling clock
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            shift <= 8'hFF;
        end else if (scl_rise && state != ST_TX) begin
            shift <= {shift[6:0], sda_s};
        end else if (state == ST_ADDR_ACK && scl_fall && rw_bit) begin
            shift <= first_tx; // RQ5
        end else if (state == ST_TX_ACK && scl_fall) begin
            shift <= next_tx; // RQ8 RQ9
        end else if (state == ST_TX && scl_fall) begin
            shift <= {shift[6:0], 1'b1}; // RQ10
        end
    end

    // Target sequencer
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state     <= ST_IDLE;
            rw_bit    <= 1'b0;
            cbyte     <= CB_RESET;
            byte_idx  <= 2'h0;
            drive_low <= 1'b0;
            stretch   <= 1'b0;
        end else if (stop_c || !en) begin
            state     <= ST_IDLE;
            drive_low <= 1'b0;
            stretch   <= 1'b0;
        end else if (start_c) begin
            state     <= ST_ADDR; // RQ1 RQ4
            drive_low <= 1'b0;
            stretch   <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE, ST_IGNORE: begin
                    drive_low <= 1'b0;
                end
                ST_ADDR: begin
                    if (got8 && scl_fall) begin
                        if (addr_hit) begin
                            rw_bit    <= shift[0];
                            drive_low <= 1'b1; // RQ2 RQ5
                            state     <= ST_ADDR_ACK;
                        end else begin
                            state     <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        byte_idx  <= 2'h0;
                        drive_low <= 1'b0;
                        state     <= rw_bit ? ST_TX : ST_CTRL; // RQ5
                    end
                end
                ST_CTRL: begin
                    if (log_push) begin
                        if (log_ready) begin
                            cbyte     <= shift; // RQ3
                            drive_low <= 1'b1; // RQ3
                            state     <= ST_CTRL_ACK;
                        end else begin
                            stretch   <= 1'b1; // Hold clock until room
                        end
                    end
                end
                ST_CTRL_ACK: begin
                    stretch   <= 1'b0; // Clock freed after ack is set up
                    if (scl_fall) begin
                        drive_low <= 1'b0;
                        state     <= ST_IGNORE; // RQ4
                    end
                end
                ST_TX: begin
                    if (got8 && scl_fall) begin
                        state     <= ST_TX_ACK;
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise && (sda_s || !more)) begin
                        state     <= ST_IGNORE; // RQ13 RQ16
                    end else if (scl_fall) begin
                        byte_idx  <= next_idx; // RQ8 RQ9
                        state     <= ST_TX;
                    end
                end
            endcase
        end
    end

    // Open-drain pin drive; data line low for ack or a zero data bit
    assign sda_out = 1'b0;
    assign scl_out = 1'b0;
    assign sda_oe  = drive_low || (state == ST_TX && !shift[7]); // RQ5
    assign scl_oe  = stretch;

    // Avalon-MM slave: one wait state per access
    assign waitrequest = req && !served;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            served <= 1'b0;
        end else begin
            served <= req && !served;
        end
    end

    // Register writes at the completing edge
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            for (int i = 0; i < 4; i++) begin
                chan[i] <= 32'h0000_0000;
            end
            ctrl <= CTRL_RESET;
        end else if (done && write) begin
            if (hit_code) begin
                chan[address[1:0]] <= (chan[address[1:0]] & ~be_mask)
                                    | (writedata & be_mask);
            end
            if (hit_ctrl) begin
                ctrl <= (ctrl & ~be_mask) | (writedata & be_mask);
            end
        end
    end

    // Read data decode, masked to documented field widths
    wire [31:0] code_rd = {18'h0, chan[address[1:0]][13:0]};
    wire [31:0] ctrl_rd = {31'h0, ctrl[CTRL_EN_BIT]};
    wire [31:0] stat_rd = {22'h0, log_valid, (state != ST_IDLE), cbyte};
    wire [31:0] log_rd  = {23'h0, log_valid, log_data};
    wire [31:0] rd_mux  = hit_code ? code_rd :
                          hit_ctrl ? ctrl_rd :
                          hit_stat ? stat_rd :
                          hit_log  ? log_rd  : 32'h0000_0000;

    // Read data captured in the wait cycle, stands at the answer edge
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            readdata <= 32'h0000_0000;
        end else if (read && !served) begin
            readdata <= rd_mux;
        end
    end
endmodule : rdbk_target

`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the two-wire readback target
`timescale 1ns/1ps
`default_nettype none
module testbench
    import rdbk_pkg::*;
;
    logic        mclk, nrst, read, write, pa_hi, pa_lo, pd, waitrequest;
    logic        scl_oe, sda_oe;
    wire logic   scl, sda;
    logic [3:0]  address, be;
    logic [31:0] writedata, readdata, q, r;
    logic [23:0] rq;
    logic [11:0] codes [4];
    logic [7:0]  c;
    logic [6:0]  a;
    logic [2:0]  acks;
    logic [1:0]  ch;
    logic [1:0]  pms [4];
    int          seed, fails, num_checks, n;
    rdbk_target uut (.mclk(mclk), .nrst(nrst), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(be), .readdata(readdata), .waitrequest(waitrequest),
        .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda),
        .sda_out(), .sda_oe(sda_oe), .pin_addr_bit_hi(pa_hi),
        .pin_addr_bit_lo(pa_lo));
    twi_master_model mst (.mclk(mclk), .scl_oe(scl_oe), .sda_oe(sda_oe),
        .scl(scl), .sda(sda));
    // Clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = !mclk;
    end
    task automatic end_of_test();
        if (fails == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Bus cycle: hold until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] ad,
                       input logic [31:0] d, output logic [31:0] qq);
        address   <= ad;
        writedata <= d;
        read      <= !wr;
        write     <= wr;
        // Values read here are those that stood before the edge
        do begin
            @(posedge mclk);
        end while (waitrequest !== 1'b0);
        qq = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        // One idle edge so the next call never rewrites the strobe
        @(posedge mclk);
    endtask : bus
    // Expected bytes; low nibble of the last byte is masked
    function automatic logic [23:0] exp_bytes(input logic [11:0] cd,
                                              input logic [1:0] pm,
                                              input logic p);
        return p ? {pm, 6'h3F, cd, 4'h0} : {8'h00, cd, 4'h0};
    endfunction : exp_bytes
    // Watchdog
    initial begin
        repeat (90000) @(posedge mclk);
        fails++;
        end_of_test();
    end
    // Main sequence
    initial begin
        {nrst, read, write, pa_hi, pa_lo} = 5'h00;
        address    = 4'h0;
        be         = 4'hF;
        writedata  = 32'h0;
        fails      = 0;
        num_checks = 0;
        seed       = 32'h3b7a;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        bus(1'b0, OFF_CODE0, 32'h0, q);
        check(q, 32'h0);
        bus(1'b0, OFF_CTRL, 32'h0, q);
        check(q, CTRL_RESET);
        bus(1'b1, 4'hF, 32'hFFFFFFFF, q);
        bus(1'b0, 4'hF, 32'h0, q);
        check(q, 32'h0);
        // Only the enabled byte lane lands
        be <= 4'h1;
        bus(1'b1, OFF_CODE0, 32'hFFFFFFFF, q);
        be <= 4'hF;
        bus(1'b0, OFF_CODE0, 32'h0, q);
        check(q, 32'h000000FF);
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            codes[k] = r[11:0];
            pms[k] = r[13:12];
            bus(1'b1, OFF_CODE0 + k[3:0], {18'h0, pms[k], codes[k]}, q);
        end
        // Every channel, with and without the power byte, two speeds
        for (int i = 0; i < 8; i++) begin
            ch = i[1:0];
            pd = i[2];
            r = $random(seed);
            codes[ch] = r[11:0];
            pms[ch] = ch ^ 2'h1;
            pa_hi <= r[12];
            pa_lo <= r[13];
            bus(1'b1, OFF_CODE0 + {2'h0, ch}, {18'h0, pms[ch], codes[ch]}, q);
            c = {r[23:19], ch, pd};
            mst.half = (i % 2 == 1) ? 32 : 20;
            mst.xfer({ADDR_FIXED, r[12], r[13]}, c, pd ? 3 : 2, rq, acks);
            check({29'h0, acks}, 32'h7);
            r = {8'h00, exp_bytes(codes[ch], pms[ch], pd)};
            rq[3:0] = 4'h0;
            check({8'h00, rq}, r);
            bus(1'b0, OFF_STATUS, 32'h0, q);
            check({22'h0, q[9:0]}, {22'h0, 2'b10, c});
            bus(1'b0, OFF_LOG, 32'h0, q);
            check({23'h0, q[8:0]}, {23'h0, 1'b1, c});
        end
        // Foreign address, then a disabled target: no acknowledge
        a = {ADDR_FIXED, pa_hi, pa_lo};
        mst.xfer({ADDR_FIXED, !pa_hi, pa_lo}, 8'h00, 0, rq, acks);
        check({29'h0, acks}, 32'h0);
        bus(1'b1, OFF_CTRL, 32'h0, q);
        mst.xfer(a, 8'h00, 0, rq, acks);
        check({29'h0, acks}, 32'h0);
        bus(1'b1, OFF_CTRL, CTRL_RESET, q);
        // Fill the log, see the clock stretched, then drain in order
        for (int i = 0; i < 16; i++) mst.xfer(a, 8'h40 + i[7:0], 0, rq, acks);
        fork
            mst.xfer(a, 8'h50, 0, rq, acks);
            begin
                for (n = 0; n < 3000 && scl_oe !== 1'b1; n++) @(posedge mclk);
                check({31'h0, scl_oe}, 32'h1);
                repeat (40) @(posedge mclk);
                bus(1'b0, OFF_LOG, 32'h0, q);
                check({23'h0, q[8:0]}, {23'h0, 9'h140});
            end
        join
        check({29'h0, acks}, 32'h6);
        for (int i = 1; i < 18; i++) begin
            bus(1'b0, OFF_LOG, 32'h0, q);
            r = (i < 17) ? {23'h0, 1'b1, 8'h40 + i[7:0]} : 32'h0;
            check({23'h0, q[8], q[8] ? q[7:0] : 8'h00}, r);
        end
        end_of_test();
    end
endmodule : testbench
`default_nettype wire

// ===== twi_master_model.sv
// Behavioural two-wire bus master facing the readback target
`timescale 1ns/1ps
`default_nettype none
module twi_master_model (
    input  wire logic mclk,
    input  wire logic scl_oe,
    input  wire logic sda_oe,
    output logic      scl,
    output logic      sda
);
    int   half;
    logic scl_lo;
    logic sda_lo;
    // Open-drain wires with pull-ups
    assign scl = !(scl_lo || scl_oe);
    assign sda = !(sda_lo || sda_oe);
    initial begin
        half   = 20;
        scl_lo = 1'b0;
        sda_lo = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk);
    endtask : wait_n
    // One bit: set in low phase, sampled mid high, waits out stretching
    task automatic clk_bit(input logic b, output logic r);
        wait_n(half / 2);
        sda_lo <= !b;
        wait_n(half / 2);
        scl_lo <= 1'b0;
        while (!scl) @(posedge mclk);
        wait_n(half / 2);
        r = sda;
        wait_n(half / 2);
        scl_lo <= 1'b1;
    endtask : clk_bit
    // Start or repeated start: data falls while clock high
    task automatic start();
        wait_n(half / 2);
        sda_lo <= 1'b0;
        wait_n(half / 2);
        scl_lo <= 1'b0;
        wait_n(half);
        sda_lo <= 1'b1;
        wait_n(half);
        scl_lo <= 1'b1;
    endtask : start
    // Stop: data rises while clock high
    task automatic stop();
        wait_n(half / 2);
        sda_lo <= 1'b1;
        wait_n(half / 2);
        scl_lo <= 1'b0;
        wait_n(half);
        sda_lo <= 1'b0;
        wait_n(half);
    endtask : stop
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
        clk_bit(1'b1, r);
        ack = !r;
    endtask : put
    task automatic get(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, r);
            d[i] = r;
        end
        clk_bit(last, r);
    endtask : get
    // Address and control byte, then optionally nb bytes read back
    task automatic xfer(input logic [6:0] a, input logic [7:0] c,
                        input int nb, output logic [23:0] q,
                        output logic [2:0] acks);
        logic [7:0] b;
        q    = 24'h000000;
        acks = 3'h0;
        start();
        put({a, 1'b0}, acks[2]);
        put(c, acks[1]);
        if (nb > 0) begin
            start();
            put({a, 1'b1}, acks[0]);
            for (int k = nb - 1; k >= 0; k--) begin
                get(k == 0, b);
                q = {q[15:0], b};
            end
        end
        stop();
    endtask : xfer
endmodule : twi_master_model
`default_nettype wire
